// [core/phy_self_status_register.sv]
// Purpose: Self status register with its management frame slave.
// Assumes: Status inputs are on core_clk_in; MDC, MDIO and straps are pins.
// Notes:   MDC is sampled as a data input, so it must run well below 25 MHz.
`timescale 1ns/1ps
`include "phy_self_status_cfg.svh"

module phy_self_status_register
(
  input  wire logic       core_clk_in,              // Device clock.
  input  wire logic       arst_n_in,                // Async reset, low.
  input  wire logic       mdc_in,                   // Management clock pin.
  input  wire logic       mdio_in,                  // Management data in.
  output logic            mdio_out,                 // Management data out.
  output logic            mdio_oe_out,              // High while driving.
  input  wire logic [4:0] phy_address_straps_in,    // Address strap pins.
  input  wire logic       repeater_strap_in,        // Repeater strap pin.
  input  wire logic       descrambler_lock_in,      // Descrambler in sync.
  input  wire logic       descrambler_timeout_in,   // Timeout pulse.
  input  wire logic       carrier_sense_raw_in,     // Unforced carrier sense.
  input  wire logic       link_unstable_in,         // Instability seen.
  input  wire logic       carrier_integrity_monitor_disable_in, // From 17h.
  input  wire logic       autoneg_enable_status_in, // Autoneg enabled.
  output logic            carrier_sense_out,        // Gated carrier sense.
  output logic            far_end_fault_indication_gen_en_out, // Generate.
  output logic            far_end_fault_indication_det_en_out  // Detect.
);
  import phy_self_status_pkg::*;

  // Pin synchronisers; the first stages are read only by the second.
  logic       mdc_s1_reg, mdc_s2_reg, mdc_s3_reg;
  logic       mdio_s1_reg, mdio_s2_reg;
  logic [5:0] strap_s1_reg, strap_s2_reg;

  // Register fields and control state.
  logic       far_end_fault_indication_en_reg, far_end_fault_indication_en_next;         // Fault enable field.
  logic       crs_tmo_reg, crs_tmo_next;         // Force-CRS control.
  logic [4:0] phy_addr_reg, phy_addr_next;       // Address field.
  logic       cim_reg, cim_next;                 // Latched integrity flag.
  logic       crs_hold_reg, crs_hold_next;       // CRS forced low.
  logic [1:0] strap_cnt_reg, strap_cnt_next;     // Strap settle count.
  logic       strap_done_reg, strap_done_next;   // Straps taken.
  logic       crs_out_reg, gen_en_reg, det_en_reg;

  // Frame receiver state.
  mf_state_t  state_reg, state_next;
  logic [5:0] ones_reg, ones_next;               // Preamble one count.
  logic [3:0] cnt_reg, cnt_next;                 // Bit count in a field.
  logic [1:0] op_reg, op_next;                   // Opcode bits.
  logic [9:0] addr_reg, addr_next;               // PHY and register address.
  logic [15:0] shift_reg, shift_next;            // Data in or out.
  logic       match_reg, match_next;             // Frame is for us.
  logic       oe_reg, oe_next;
  logic       dout_reg, dout_next;

  // Combinational helpers.
  logic       mdc_rise;                          // Sampled MDC rising edge.
  logic       read_clear;                        // Read snapshot this cycle.
  logic       write_commit;                      // Write lands this cycle.
  logic       cim_set;                           // Instability event.
  word_t      status_word;                       // Live read value.
  word_t      write_word;                        // Word as a write commits.

  // Synchronise the pins; straps too, since they may move near reset.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mdc_s1_reg   <= 1'h0;
      mdc_s2_reg   <= 1'h0;
      mdc_s3_reg   <= 1'h0;
      mdio_s1_reg  <= 1'h1;
      mdio_s2_reg  <= 1'h1;
      strap_s1_reg <= 6'h00;
      strap_s2_reg <= 6'h00;
    end
    else
    begin
      mdc_s1_reg   <= mdc_in;
      mdc_s2_reg   <= mdc_s1_reg;
      mdc_s3_reg   <= mdc_s2_reg;
      mdio_s1_reg  <= mdio_in;
      mdio_s2_reg  <= mdio_s1_reg;
      strap_s1_reg <= {repeater_strap_in, phy_address_straps_in};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // Edge of the synchronised MDC, built only from the later stages.
  assign mdc_rise = mdc_s2_reg & ~mdc_s3_reg;

  // Full write word at the 16th data edge: 15 shifted bits plus the last.
  // A named net is needed because a concatenation cannot be indexed.
  assign write_word = {shift_reg[14:0], mdio_s2_reg};

  // Live read value; unlisted bits read as zero.
  always_comb
  begin
    status_word                = 16'h0000;
    status_word[`BIT_DSC_LOCK] = descrambler_lock_in;
    status_word[`BIT_CRS_TMO]  = crs_tmo_reg;
    status_word[`BIT_AN_EN]    = autoneg_enable_status_in;
    status_word[`BIT_FAR_END_FAULT_INDICATION_EN]  = far_end_fault_indication_en_reg;
    status_word[`BIT_CIM]      = cim_reg;
    status_word[4:0]           = phy_addr_reg;
  end

  // Frame receiver: preamble, start, opcode, addresses, turnaround, data.
  always_comb
  begin
    state_next   = state_reg;
    ones_next    = ones_reg;
    cnt_next     = cnt_reg;
    op_next      = op_reg;
    addr_next    = addr_reg;
    shift_next   = shift_reg;
    match_next   = match_reg;
    oe_next      = oe_reg;
    dout_next    = dout_reg;
    read_clear   = 1'h0;
    write_commit = 1'h0;
    if (mdc_rise)
    begin
      case (state_reg)
        MF_PREAMBLE:
        begin
          // A zero after a full preamble is the first start bit.
          if (mdio_s2_reg)
            ones_next = (ones_reg == `PREAMBLE_ONES) ? ones_reg
                                                     : ones_reg + 6'h01;
          else
          begin
            if (ones_reg == `PREAMBLE_ONES)
              state_next = MF_START;
            ones_next = 6'h00;
          end
        end
        MF_START:
        begin
          // The second start bit must be one, else hunt again.
          state_next = mdio_s2_reg ? MF_OPCODE : MF_PREAMBLE;
          cnt_next   = 4'h0;
        end
        MF_OPCODE:
        begin
          op_next  = {op_reg[0], mdio_s2_reg};
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == 4'h1)
          begin
            state_next = MF_ADDRESS;
            cnt_next   = 4'h0;
          end
        end
        MF_ADDRESS:
        begin
          addr_next = {addr_reg[8:0], mdio_s2_reg};
          cnt_next  = cnt_reg + 4'h1;
          if (cnt_reg == `LAST_ADDR_BIT)
          begin
            // Only our own address and register are answered.
            match_next = (addr_reg[8:4] == phy_addr_reg) &&
                         ({addr_reg[3:0], mdio_s2_reg} ==
                          `SELF_STATUS_REG_ADDR);
            state_next = MF_TURN;
            cnt_next   = 4'h0;
          end
        end
        MF_TURN:
        begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == 4'h0)
          begin
            // Drive the second turnaround bit low on a read.
            if (match_reg && op_reg == `OP_READ)
            begin
              oe_next    = 1'h1;
              dout_next  = 1'h0;
              shift_next = status_word;
              read_clear = 1'h1;
            end
          end
          else
          begin
            state_next = MF_DATA;
            cnt_next   = 4'h0;
            dout_next  = shift_reg[15];
            shift_next = {shift_reg[14:0], 1'h0};
          end
        end
        MF_DATA:
        begin
          cnt_next = cnt_reg + 4'h1;
          if (oe_reg)
          begin
            dout_next  = shift_reg[15];
            shift_next = {shift_reg[14:0], 1'h0};
          end
          else
            shift_next = {shift_reg[14:0], mdio_s2_reg};
          if (cnt_reg == `LAST_DATA_BIT)
          begin
            oe_next      = 1'h0;
            state_next   = MF_PREAMBLE;
            ones_next    = 6'h00;
            write_commit = match_reg && (op_reg == `OP_WRITE);
          end
        end
        default:
        begin
          state_next = MF_PREAMBLE;
          oe_next    = 1'h0;
        end
      endcase
    end
  end

  // Register fields, latched flag, straps and carrier sense forcing.
  always_comb
  begin
    far_end_fault_indication_en_next    = far_end_fault_indication_en_reg;
    crs_tmo_next    = crs_tmo_reg;
    phy_addr_next   = phy_addr_reg;
    strap_cnt_next  = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    crs_hold_next   = crs_hold_reg;
    // Straps are taken once the synchroniser holds post-reset levels.
    if (!strap_done_reg)
    begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == `STRAP_SETTLE)
      begin
        phy_addr_next   = strap_s2_reg[4:0];
        crs_tmo_next    = ~strap_s2_reg[5];
        strap_done_next = 1'h1;
      end
    end
    // Only the writable fields take write data.
    if (write_commit)
    begin
      crs_tmo_next  = write_word[`BIT_CRS_TMO];
      far_end_fault_indication_en_next  = write_word[`BIT_FAR_END_FAULT_INDICATION_EN];
      phy_addr_next = write_word[4:0];
    end
    // Hold CRS low from a timeout until lock returns.
    if (descrambler_lock_in)
      crs_hold_next = 1'h0;
    else if (descrambler_timeout_in && crs_tmo_reg)
      crs_hold_next = 1'h1;
    // A new instability wins over the clear from a read.
    cim_set  = link_unstable_in && !carrier_integrity_monitor_disable_in;
    cim_next = cim_set ? 1'h1 : (read_clear ? 1'h0 : cim_reg);
  end

  // Register all state; outputs come straight from these flops.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg      <= MF_PREAMBLE;
      ones_reg       <= 6'h00;
      cnt_reg        <= 4'h0;
      op_reg         <= 2'h0;
      addr_reg       <= 10'h000;
      shift_reg      <= 16'h0000;
      match_reg      <= 1'h0;
      oe_reg         <= 1'h0;
      dout_reg       <= 1'h0;
      far_end_fault_indication_en_reg    <= `RST_FAR_END_FAULT_INDICATION_EN;
      crs_tmo_reg    <= `RST_CRS_TMO;
      phy_addr_reg   <= `RST_PHY_ADDR;
      cim_reg        <= 1'h0;
      crs_hold_reg   <= 1'h0;
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'h0;
      crs_out_reg    <= 1'h0;
      gen_en_reg     <= 1'h0;
      det_en_reg     <= 1'h0;
    end
    else
    begin
      state_reg      <= state_next;
      ones_reg       <= ones_next;
      cnt_reg        <= cnt_next;
      op_reg         <= op_next;
      addr_reg       <= addr_next;
      shift_reg      <= shift_next;
      match_reg      <= match_next;
      oe_reg         <= oe_next;
      dout_reg       <= dout_next;
      far_end_fault_indication_en_reg    <= far_end_fault_indication_en_next;
      crs_tmo_reg    <= crs_tmo_next;
      phy_addr_reg   <= phy_addr_next;
      cim_reg        <= cim_next;
      crs_hold_reg   <= crs_hold_next;
      strap_cnt_reg  <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
      crs_out_reg    <= carrier_sense_raw_in & ~crs_hold_next;
      gen_en_reg     <= far_end_fault_indication_en_next & ~autoneg_enable_status_in;
      det_en_reg     <= far_end_fault_indication_en_next & ~autoneg_enable_status_in;
    end
  end

  assign mdio_out                            = dout_reg;
  assign mdio_oe_out                         = oe_reg;
  assign carrier_sense_out                   = crs_out_reg;
  assign far_end_fault_indication_gen_en_out = gen_en_reg;
  assign far_end_fault_indication_det_en_out = det_en_reg;

  // Checks on the block's own outputs and state.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_lock_live: assert property (read_clear |=>
    shift_reg[`BIT_DSC_LOCK] == $past(descrambler_lock_in))
    else $error("Lock bit snapshot differs from lock input.");
  a_crs_forced: assert property (crs_hold_reg && !descrambler_lock_in
    |=> !carrier_sense_out)
    else $error("Carrier sense not held low after timeout.");
  a_crs_release: assert property (descrambler_lock_in |=> !crs_hold_reg)
    else $error("Carrier sense hold outlived descrambler lock.");
  a_far_end_fault_indication_gate: assert property (##1 far_end_fault_indication_gen_en_out
    == ($past(far_end_fault_indication_en_next) && !$past(autoneg_enable_status_in)))
    else $error("Fault machine enable wrong.");
  a_cim_latch: assert property (cim_set |=> cim_reg [*2] or
    (cim_reg ##1 1'b1))
    else $error("Integrity flag not latched.");
  a_cim_hold: assert property (cim_reg && !read_clear |=> cim_reg)
    else $error("Integrity flag dropped without a read.");
  a_cim_clear: assert property (read_clear && !cim_set |=> !cim_reg)
    else $error("Read did not clear integrity flag.");
  a_strap_take: assert property (!strap_done_reg &&
    strap_cnt_reg == `STRAP_SETTLE |=> phy_addr_reg == $past(strap_s2_reg[4:0]))
    else $error("Address straps not captured.");
  a_foreign_quiet: assert property (mdio_oe_out |-> match_reg)
    else $error("Drove MDIO for another address.");
  a_ro_write: assert property (write_commit |=>
    far_end_fault_indication_en_reg == $past(shift_reg[7]) && cim_reg == $past(cim_next))
    else $error("Write handling of fields wrong.");

  c_read: cover property (read_clear ##[1:400] !mdio_oe_out);
  c_write: cover property (write_commit);
  c_cim_cleared: cover property (cim_reg && read_clear ##1 !cim_reg);
  c_crs_forced: cover property (carrier_sense_raw_in && crs_hold_reg);

endmodule // phy_self_status_register

// [core/phy_self_status_cfg.svh]
// Purpose: Constants for the self status register block.
// Assumes: Included by its bare name; definitions only.
// Notes:   Bit positions refer to the 16-bit self status word.
// What this block does
// - Lock bit shows live descrambler synchronisation.
// - Optionally force carrier sense low after timeout.
// - Fault machines enabled when enable set, autoneg clear.
// - Integrity bit set and latched on instability.
// - Reading this register clears latched integrity bit.
// - Address field loaded from straps at reset.
// - Answer management frames only at own address.
`ifndef PHY_SELF_STATUS_CFG_SVH
`define PHY_SELF_STATUS_CFG_SVH

// Register index of the self status register.
`define SELF_STATUS_REG_ADDR 5'h19
// Field positions inside the 16-bit word.
`define BIT_DSC_LOCK   4'hC
`define BIT_CRS_TMO    4'hB
`define BIT_AN_EN      4'hA
`define BIT_FAR_END_FAULT_INDICATION_EN    4'h8
`define BIT_CIM        4'h5
// Reset values of the writable fields before the straps are taken.
`define RST_FAR_END_FAULT_INDICATION_EN    1'h0
`define RST_CRS_TMO    1'h0
`define RST_PHY_ADDR   5'h00
// Management frame constants.
`define PREAMBLE_ONES  6'h20
`define OP_READ        2'h2
`define OP_WRITE       2'h1
`define LAST_DATA_BIT  4'hF
`define LAST_ADDR_BIT  4'h9
// Cycles after reset release before the synchronised straps are taken.
`define STRAP_SETTLE   2'h2

`endif

// [core/phy_self_status_pkg.sv]
// Purpose: Types for the self status register block.
// Assumes: Constants live in phy_self_status_cfg.svh.
// Notes:   Gray codes from MF_PREAMBLE through MF_DATA; the step from MF_DATA back to MF_PREAMBLE is not.
package phy_self_status_pkg;

  // Management frame receiver states.
  typedef enum logic [2:0] {
    MF_PREAMBLE = 3'h0,
    MF_START    = 3'h1,
    MF_OPCODE   = 3'h3,
    MF_ADDRESS  = 3'h2,
    MF_TURN     = 3'h6,
    MF_DATA     = 3'h7
  } mf_state_t;

  // Register word type.
  typedef logic [15:0] word_t;

endpackage

// [sim/mdio_station_model.sv]
// Purpose: Station management controller that sends MDIO frames.
// Assumes: MDC half period is a whole number of core clocks.
// Notes:   MDC stands low between frames; the line has a pull-up.
`timescale 1ns/1ps

module mdio_station_model
#(
  parameter int HALF = 6 // Core clocks per MDC half period.
)
(
  input  wire logic clk_in,   // Core clock, paces the frame.
  input  wire logic line_in,  // Resolved MDIO line level.
  output logic      mdc_out,  // Management clock.
  output logic      mdio_out, // Data this model drives.
  output logic      oe_out    // High while this model drives.
);
  // Quiet line and still clock until the first frame.
  initial
  begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    oe_out = 1'b0;
  end

  // One frame, bit 63 first. Data changes while MDC is low, so the
  // device never samples it mid-change. A read lets go of the line
  // from the turnaround on; cap[16] is the second turnaround bit.
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] rg, input logic [15:0] wd,
                       output logic [15:0] rd, output logic ta);
    logic [63:0] tx;
    logic [63:0] cap;
    tx = {32'hFFFF_FFFF, 2'h1, op, phy, rg, 2'h2, wd};
    for (int i = 63; i >= 0; i--)
    begin
      mdc_out <= 1'b0;
      mdio_out <= tx[i];
      oe_out <= (op == 2'h1) || (i > 17);
      repeat (HALF) @(posedge clk_in);
      cap[i] = line_in;
      mdc_out <= 1'b1;
      repeat (HALF) @(posedge clk_in);
    end
    mdc_out <= 1'b0;
    oe_out <= 1'b0;
    // Idle gap, so a following frame never re-drives in this time step.
    repeat (HALF) @(posedge clk_in);
    rd = cap[15:0];
    ta = cap[16];
  endtask
endmodule // mdio_station_model

// [sim/phy_self_status_register_tb.sv]
// Purpose: Self-checking bench for the self status register.
// Assumes: Status inputs change only at core clock rising edges.
// Notes:   Refused reads see the pull-up, so they return all ones.
`timescale 1ns/1ps

module phy_self_status_register_tb;
  import phy_self_status_pkg::*;

  logic        core_clk_in = 1'b0; // Device clock.
  logic        arst_n_in = 1'b0;   // Async reset, low.
  logic        mdc;                // Management clock.
  logic        host_d;             // Host data.
  logic        host_oe;            // Host drive enable.
  logic        dev_d;              // Device data.
  logic        dev_oe;             // Device drive enable.
  logic [4:0]  straps = 5'h15;     // Address strap levels.
  logic        rep = 1'b0;         // Repeater strap level.
  logic        lock = 1'b0;        // Descrambler in sync.
  logic        tmo = 1'b0;         // Descrambler timeout.
  logic        raw = 1'b0;         // Unforced carrier sense.
  logic        unst = 1'b0;        // Link instability.
  logic        cdis = 1'b0;        // Integrity monitor disable.
  logic        an = 1'b0;          // Autoneg enabled.
  logic        crs;                // Gated carrier sense.
  logic        gen;                // Fault generate enable.
  logic        det;                // Fault detect enable.
  logic [15:0] rd;                 // Last read word.
  logic        ta;                 // Last turnaround bit.
  int          mismatches = 0;     // Failed comparisons.
  int          compares = 0;       // All comparisons.
  wire         line = dev_oe ? dev_d : (host_oe ? host_d : 1'b1);

  // Free running 100 MHz clock.
  initial
  begin
    forever #5 core_clk_in = ~core_clk_in;
  end

  mdio_station_model host (.clk_in(core_clk_in), .line_in(line),
    .mdc_out(mdc), .mdio_out(host_d), .oe_out(host_oe));

  phy_self_status_register dut (.core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in), .mdc_in(mdc), .mdio_in(line),
    .mdio_out(dev_d), .mdio_oe_out(dev_oe),
    .phy_address_straps_in(straps), .repeater_strap_in(rep),
    .descrambler_lock_in(lock), .descrambler_timeout_in(tmo),
    .carrier_sense_raw_in(raw), .link_unstable_in(unst),
    .carrier_integrity_monitor_disable_in(cdis),
    .autoneg_enable_status_in(an), .carrier_sense_out(crs),
    .far_end_fault_indication_gen_en_out(gen),
    .far_end_fault_indication_det_en_out(det));

  // Count and report one comparison.
  task automatic check(input logic [16:0] got, input logic [16:0] exp,
                       input string what);
    compares++;
    if (got !== exp)
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    if (got !== exp)
      mismatches++;
  endtask

  // Wait a number of core clocks.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  // Read and compare turnaround bit with the word.
  task automatic rdc(input logic [4:0] a, input logic [4:0] r,
                     input logic [16:0] exp, input string what);
    host.frame(2'h2, a, r, 16'h0000, rd, ta);
    check({ta, rd}, exp, what);
  endtask

  // Write one word.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    host.frame(2'h1, a, 5'h19, d, rd, ta);
    cyc(3);
  endtask

  // Enables follow bit 8 and the autoneg status together.
  task automatic fault_en(input logic [1:0] exp, input string what);
    cyc(3);
    check({15'h0, gen, det}, {15'h0, exp}, what);
  endtask

  // Reset value from straps, then live status bits.
  task automatic t_reset();
    rdc(5'h15, 5'h19, {1'b0, 16'h0815}, "reset word");
    lock <= 1'b1;
    an <= 1'b1;
    rdc(5'h15, 5'h19, {1'b0, 16'h1C15}, "live bits");
    lock <= 1'b0;
    an <= 1'b0;
    $display("done reset");
  endtask

  // Only our address and register answer; address is writable.
  task automatic t_addr();
    rdc(5'h14, 5'h19, {1'b1, 16'hFFFF}, "other phy");
    rdc(5'h15, 5'h18, {1'b1, 16'hFFFF}, "other reg");
    wr(5'h14, 16'h0100);
    rdc(5'h15, 5'h19, {1'b0, 16'h0815}, "foreign write");
    wr(5'h15, 16'h000A);
    rdc(5'h0A, 5'h19, {1'b0, 16'h000A}, "new address");
    rdc(5'h15, 5'h19, {1'b1, 16'hFFFF}, "old address");
    $display("done addr");
  endtask

  // Read-only bits ignore writes; fault machines follow bit 8.
  task automatic t_fault();
    wr(5'h0A, 16'hFFFF);
    rdc(5'h1F, 5'h19, {1'b0, 16'h091F}, "ro bits");
    fault_en(2'h3, "fault on");
    an <= 1'b1;
    fault_en(2'h0, "autoneg blocks");
    an <= 1'b0;
    wr(5'h1F, 16'h081F);
    fault_en(2'h0, "fault off");
    $display("done fault");
  endtask

  // Integrity bit latches until read, unless disabled.
  task automatic t_cim();
    unst <= 1'b1;
    cyc(1);
    unst <= 1'b0;
    rdc(5'h1F, 5'h19, {1'b0, 16'h083F}, "latched");
    rdc(5'h1F, 5'h19, {1'b0, 16'h081F}, "read clear");
    cdis <= 1'b1;
    unst <= 1'b1;
    cyc(1);
    unst <= 1'b0;
    rdc(5'h1F, 5'h19, {1'b0, 16'h081F}, "disabled");
    cdis <= 1'b0;
    $display("done cim");
  endtask

  // Carrier sense held low after timeout until lock returns.
  task automatic t_crs(input logic [15:0] w, input logic hold);
    wr(5'h1F, w);
    lock <= 1'b1;
    raw <= 1'b1;
    cyc(3);
    check({16'h0, crs}, 17'h1, "crs idle");
    tmo <= 1'b1;
    lock <= 1'b0;
    cyc(1);
    tmo <= 1'b0;
    cyc(6);
    check({16'h0, crs}, {16'h0, ~hold}, "crs held");
    lock <= 1'b1;
    cyc(3);
    check({16'h0, crs}, 17'h1, "crs back");
    lock <= 1'b0;
    $display("done crs");
  endtask

  // A reset in mid-run takes the new straps, repeater inverted into bit 11.
  task automatic t_reset2();
    arst_n_in <= 1'b0;
    rep <= 1'b1;
    straps <= 5'h03;
    cyc(3);
    arst_n_in <= 1'b1;
    cyc(6);
    rdc(5'h03, 5'h19, {1'b0, 16'h0003}, "second reset");
    $display("done second reset");
  endtask

  // Print the counts and the verdict, then stop.
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence; a second reset retakes the straps.
  initial
  begin
    cyc(3);
    arst_n_in <= 1'b1;
    cyc(6);
    t_reset();
    t_addr();
    t_fault();
    t_cim();
    t_crs(16'h081F, 1'b1);
    t_crs(16'h001F, 1'b0);
    t_reset2();
    test_done();
  end

  // Cut a hang short well past the expected run length.
  initial
  begin
    cyc(60000);
    mismatches++;
    test_done();
  end
endmodule // phy_self_status_register_tb
